// File: vmseq_pkg.sv
package vmseq_pkg;
	// clock and conversion timing
	localparam int CLK_MHZ = 10;
	localparam int SINGLE_CHANNEL_CONVERT_TIME_US = 700; // one conversion, 0.7 ms
	localparam int CYCLE_TIME_US = 146500; // default pass, 146.5 ms
	localparam int SLOW_TIME_US = 240000; // slow pass, 240 ms
	localparam int SINGLE_CHANNEL_CONVERT_CYCLES_DEF = SINGLE_CHANNEL_CONVERT_TIME_US * CLK_MHZ;
	localparam int CYCLE_CYCLES_DEF = CYCLE_TIME_US * CLK_MHZ;
	localparam int SLOW_CYCLES_DEF = SLOW_TIME_US * CLK_MHZ;
	localparam int AVG_SHIFT = 4; // sixteen samples
	localparam int NCH = 7;
	localparam int CODE_W = 10;
	localparam logic [CODE_W-1:0] NOMINAL_CODE = 10'h300; // 3/4 scale

	// register offsets, channel order: 2v5, core, supply, 5v, 12v,
	// termination, current sense
	localparam logic [7:0] READ_OFS [NCH] =
		'{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h1E, 8'h1D};
	localparam logic [7:0] LOW_OFS [NCH] =
		'{8'h44, 8'h46, 8'h48, 8'h4A, 8'h4C, 8'h84, 8'h85};
	localparam logic [7:0] HIGH_OFS [NCH] =
		'{8'h45, 8'h47, 8'h49, 8'h4B, 8'h4D, 8'h86, 8'h87};
	localparam logic [7:0] EXT_A_OFS = 8'h1F;
	localparam logic [7:0] EXT_B_OFS = 8'h76;
	localparam logic [7:0] EXT_C_OFS = 8'h77;
	localparam logic [7:0] CFG2_OFS = 8'h73;
	localparam logic [7:0] CFG4_OFS = 8'h7D;
	localparam logic [7:0] CFG6_OFS = 8'h10;
	localparam logic [7:0] CHSEL_OFS = 8'h55;
	localparam logic [7:0] STATUS_OFS = 8'h41;
	localparam logic [7:0] MASK_OFS = 8'h42;

	// field positions
	localparam int AVG_OFF_BIT = 4;
	localparam int BYP_ALL_BIT = 5;
	localparam int SINGLE_BIT = 6;
	localparam int SLOW_BIT = 7;
	localparam int CHSEL_LSB = 4;
	localparam int BYP_2V5_BIT = 4;
	localparam int BYP_CORE_BIT = 5;
	localparam int BYP_5V_BIT = 6;
	localparam int BYP_12V_BIT = 7;
	localparam int ATT_CHANS = 5; // channels with an attenuator

	// reset values
	localparam logic [7:0] LOW_RST = 8'h00;
	localparam logic [7:0] HIGH_RST = 8'hFF;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] READ_RST = 8'h00;

	// single-channel select codes for the two extra inputs and the last voltage input
	localparam logic [3:0] SEL_TERM = 4'h8;
	localparam logic [3:0] SEL_CURR = 4'h9;
	localparam logic [3:0] SEL_VLAST = 4'h4;

	// extended-bit groups: which channels each register holds
	localparam logic [NCH-1:0] EXT_A_CH = 7'h63; // 2v5, core, term, curr
	localparam logic [NCH-1:0] EXT_B_CH = 7'h1C; // supply, 5v, 12v

	typedef struct packed {
		logic rd;
		logic wr;
		logic ara;
		logic [7:0] addr;
		logic [7:0] wdata;
	} vmseq_req_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SINGLE_CHANNEL_CONVERT = 3'b010,
		ST_WAIT = 3'b100
	} vmseq_state_t;
endpackage

// File: vmseq_top.sv
// How it works
// - one shared converter digitises all seven channels as ten-bit codes.
// - nominal supply reads as code 768; headroom above stays readable.
// - averaging on, each conversion 0.7 ms, sixteen averaged per reading.
// - reading above high or below low limit sets that channel's status.
// - unmasked out-of-limit status drives the active-low alert line.
// - reading an extended register freezes matching readings until read.
// - averaging-off bit stores single conversions, sixteen times faster.
// - averaging off, each voltage channel measures in 0.7 ms.
// - default round-robin pass takes 146.5 ms.
// - slow bit stretches the round-robin pass to 240 ms.
// - bypass-all bit removes attenuators from the five supply inputs.
// - per-channel bypass bits for 2.5 V, core, 5 V and 12 V.
// - single-channel bit replaces round-robin with one channel.
// - alert response read returns own address while alert is low.
// - status read releases alert only once the fault is gone.
// - single mode samples channel from select bits every 0.7 ms.
`timescale 1ns/100ps
`default_nettype none
module vmseq_top
	import vmseq_pkg::*;
#(
	parameter int SINGLE_CHANNEL_CONVERT_CYCLES = SINGLE_CHANNEL_CONVERT_CYCLES_DEF,
	parameter int CYCLE_CYCLES = CYCLE_CYCLES_DEF,
	parameter int SLOW_CYCLES = SLOW_CYCLES_DEF,
	parameter logic [6:0] DEV_ADDR = 7'h2E // arbitrary value
) (
	input wire logic clock,
	input wire logic rst,
	input wire vmseq_req_t req,
	input wire logic [CODE_W-1:0] adc_code,
	output logic [7:0] reg_rdata_q,
	output logic ara_ack_q,
	output logic [2:0] adc_chan_q,
	output logic adc_bypass_q,
	output logic adc_sample_q,
	output logic alert_out_q,
	output logic alert_oe_q
);
	// register storage
	logic [7:0] low_q [NCH];
	logic [7:0] high_q [NCH];
	logic [CODE_W-1:0] val_q [NCH];
	logic [NCH-1:0] lock_q;
	logic [NCH-1:0] oor_q;
	logic [NCH-1:0] status_q;
	logic [NCH-1:0] mask_q;
	logic [7:0] cfg2_q;
	logic [7:0] cfg4_q;
	logic [7:0] cfg6_q;
	logic [7:0] chsel_q;

	// sequencer state
	vmseq_state_t state_q;
	logic [22:0] single_channel_convert_cnt_q;
	logic [22:0] pass_cnt_q;
	logic [3:0] avg_n_q;
	logic [CODE_W+AVG_SHIFT-1:0] acc_q;
	logic store_q;
	logic [CODE_W-1:0] result_q;
	logic [2:0] res_ch_q;

	// finds the channel whose offset table holds an address
	function automatic logic [3:0] find_ch(input logic [7:0] a,
			input logic [7:0] tbl [NCH]);
		logic [3:0] r;
		r = 4'hF;
		for (int i = 0; i < NCH; i++) begin
			if (tbl[i] == a) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	// maps single-channel select code to a channel index
	function automatic logic [2:0] sel_ch(input logic [3:0] s);
		logic [2:0] r;
		r = 3'h0;
		if (s <= SEL_VLAST) begin
			r = s[2:0];
		end else if (s == SEL_TERM) begin
			r = 3'h5;
		end else if (s == SEL_CURR) begin
			r = 3'h6;
		end
		return r;
	endfunction

	// packs two extended bits per channel of a group
	function automatic logic [7:0] ext_pack(input logic [NCH-1:0] grp,
			input logic [CODE_W-1:0] v [NCH]);
		logic [7:0] r;
		int k;
		r = 8'h00;
		k = 0;
		for (int i = 0; i < NCH; i++) begin
			if (grp[i]) begin
				r[k*2 +: 2] = v[i][1:0];
				k++;
			end
		end
		return r;
	endfunction

	logic avg_off;
	logic single;
	logic [22:0] pass_len;
	logic single_channel_convert_end;
	logic [3:0] rd_ch;
	logic [3:0] lo_ch;
	logic [3:0] hi_ch;
	logic [2:0] single_ch;
	logic [CODE_W+AVG_SHIFT-1:0] acc_sum;

	assign avg_off = cfg2_q[AVG_OFF_BIT];
	assign single = cfg2_q[SINGLE_BIT];
	assign single_ch = sel_ch(chsel_q[CHSEL_LSB +: 4]);
	assign rd_ch = find_ch(req.addr, READ_OFS);
	assign lo_ch = find_ch(req.addr, LOW_OFS);
	assign hi_ch = find_ch(req.addr, HIGH_OFS);
	assign single_channel_convert_end = (state_q == ST_SINGLE_CHANNEL_CONVERT) &&
		(single_channel_convert_cnt_q == 23'(SINGLE_CHANNEL_CONVERT_CYCLES - 1));
	assign acc_sum = acc_q + (CODE_W+AVG_SHIFT)'(adc_code);
	// pass length, shortened sixteenfold with averaging off
	assign pass_len = slow_len(cfg6_q[SLOW_BIT], avg_off);

	function automatic logic [22:0] slow_len(input logic slow,
			input logic aoff);
		logic [22:0] r;
		r = slow ? 23'(SLOW_CYCLES) : 23'(CYCLE_CYCLES);
		if (aoff) begin
			r = r >> AVG_SHIFT;
		end
		return r;
	endfunction

	// host writes to configuration and limit registers
	always_ff @(posedge clock) begin
		if (rst) begin
			for (int i = 0; i < NCH; i++) begin
				low_q[i] <= LOW_RST;
				high_q[i] <= HIGH_RST;
			end
			cfg2_q <= CFG_RST;
			cfg4_q <= CFG_RST;
			cfg6_q <= CFG_RST;
			chsel_q <= CFG_RST;
			mask_q <= '0;
		end else if (req.wr) begin
			if (lo_ch != 4'hF) begin
				low_q[lo_ch[2:0]] <= req.wdata;
			end
			if (hi_ch != 4'hF) begin
				high_q[hi_ch[2:0]] <= req.wdata;
			end
			case (req.addr)
				CFG2_OFS: cfg2_q <= req.wdata;
				CFG4_OFS: cfg4_q <= req.wdata;
				CFG6_OFS: cfg6_q <= req.wdata;
				CHSEL_OFS: chsel_q <= req.wdata;
				MASK_OFS: mask_q <= req.wdata[NCH-1:0];
				default: ;
			endcase
		end
	end

	// conversion sequencer: round-robin or single channel
	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= ST_IDLE;
			single_channel_convert_cnt_q <= '0;
			pass_cnt_q <= '0;
			avg_n_q <= '0;
			acc_q <= '0;
			adc_chan_q <= '0;
			adc_sample_q <= 1'b0;
			store_q <= 1'b0;
			result_q <= '0;
			res_ch_q <= '0;
		end else begin
			adc_sample_q <= single_channel_convert_end;
			store_q <= 1'b0;
			pass_cnt_q <= (pass_cnt_q >= pass_len - 23'd1) ?
				'0 : pass_cnt_q + 23'd1;
			case (state_q)
				ST_IDLE: begin
					adc_chan_q <= single ? single_ch : 3'h0;
					single_channel_convert_cnt_q <= '0;
					avg_n_q <= '0;
					acc_q <= '0;
					// idle cycle is the first cycle of the pass
					pass_cnt_q <= 23'd1;
					state_q <= ST_SINGLE_CHANNEL_CONVERT;
				end
				ST_SINGLE_CHANNEL_CONVERT: begin
					single_channel_convert_cnt_q <= single_channel_convert_end ? '0 : single_channel_convert_cnt_q + 23'd1;
					if (single_channel_convert_end) begin
						res_ch_q <= adc_chan_q;
						if (single || avg_off) begin
							result_q <= adc_code;
							store_q <= 1'b1;
						end else begin
							acc_q <= (avg_n_q == 4'hF) ? '0 : acc_sum;
							avg_n_q <= avg_n_q + 4'd1;
							if (avg_n_q == 4'hF) begin
								result_q <= acc_sum[AVG_SHIFT +: CODE_W];
								store_q <= 1'b1;
							end
						end
						if (single) begin
							adc_chan_q <= single_ch;
						end else if (avg_off || avg_n_q == 4'hF) begin
							if (adc_chan_q == 3'(NCH - 1)) begin
								state_q <= ST_WAIT;
							end else begin
								adc_chan_q <= adc_chan_q + 3'd1;
							end
						end
					end
				end
				ST_WAIT: begin
					// hold until the pass period runs out or single mode is set
					if (single || pass_cnt_q >= pass_len - 23'd1) begin
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// attenuator bypass for the channel being converted
	always_ff @(posedge clock) begin
		if (rst) begin
			adc_bypass_q <= 1'b0;
		end else begin
			case (adc_chan_q)
				3'h0: adc_bypass_q <= cfg2_q[BYP_ALL_BIT] |
					cfg4_q[BYP_2V5_BIT];
				3'h1: adc_bypass_q <= cfg2_q[BYP_ALL_BIT] |
					cfg4_q[BYP_CORE_BIT];
				3'h2: adc_bypass_q <= cfg2_q[BYP_ALL_BIT];
				3'h3: adc_bypass_q <= cfg2_q[BYP_ALL_BIT] |
					cfg4_q[BYP_5V_BIT];
				3'h4: adc_bypass_q <= cfg2_q[BYP_ALL_BIT] |
					cfg4_q[BYP_12V_BIT];
				default: adc_bypass_q <= 1'b0;
			endcase
		end
	end

	// reading store, freeze and limit compare
	logic [NCH-1:0] status_clr;
	logic [NCH-1:0] hit;
	assign status_clr = (req.rd && req.addr == STATUS_OFS) ? ~oor_q : '0;
	assign hit = (result_q[CODE_W-1 -: 8] > high_q[res_ch_q] ||
		result_q[CODE_W-1 -: 8] < low_q[res_ch_q]) ?
		NCH'(1) << res_ch_q : '0;

	always_ff @(posedge clock) begin
		if (rst) begin
			for (int i = 0; i < NCH; i++) begin
				val_q[i] <= {READ_RST, 2'b00};
			end
			lock_q <= '0;
			oor_q <= '0;
			status_q <= '0;
		end else begin
			if (store_q && !lock_q[res_ch_q]) begin
				val_q[res_ch_q] <= result_q;
			end
			if (store_q) begin
				oor_q[res_ch_q] <= hit[res_ch_q];
			end
			// set wins over the clear from a status read
			status_q <= (status_q & ~status_clr) |
				(store_q ? hit : '0);
			if (req.rd) begin
				if (req.addr == EXT_A_OFS) begin
					lock_q <= lock_q | EXT_A_CH;
				end else if (req.addr == EXT_B_OFS) begin
					lock_q <= lock_q | EXT_B_CH;
				end else if (rd_ch != 4'hF) begin
					lock_q[rd_ch[2:0]] <= 1'b0;
				end
			end
		end
	end

	// host read data and alert response
	always_ff @(posedge clock) begin
		if (rst) begin
			reg_rdata_q <= 8'h00;
			ara_ack_q <= 1'b0;
		end else begin
			ara_ack_q <= req.ara && alert_oe_q;
			if (req.ara) begin
				reg_rdata_q <= alert_oe_q ? {DEV_ADDR, 1'b0} : 8'h00;
			end else if (req.rd) begin
				if (rd_ch != 4'hF) begin
					reg_rdata_q <= val_q[rd_ch[2:0]][CODE_W-1 -: 8];
				end else if (lo_ch != 4'hF) begin
					reg_rdata_q <= low_q[lo_ch[2:0]];
				end else if (hi_ch != 4'hF) begin
					reg_rdata_q <= high_q[hi_ch[2:0]];
				end else begin
					case (req.addr)
						EXT_A_OFS: reg_rdata_q <= ext_pack(EXT_A_CH, val_q);
						EXT_B_OFS: reg_rdata_q <= ext_pack(EXT_B_CH, val_q);
						CFG2_OFS: reg_rdata_q <= cfg2_q;
						CFG4_OFS: reg_rdata_q <= cfg4_q;
						CFG6_OFS: reg_rdata_q <= cfg6_q;
						CHSEL_OFS: reg_rdata_q <= chsel_q;
						STATUS_OFS: reg_rdata_q <= 8'(status_q);
						MASK_OFS: reg_rdata_q <= 8'(mask_q);
						default: reg_rdata_q <= 8'h00;
					endcase
				end
			end
		end
	end

	// open-drain alert: pin driven low while an unmasked flag stands
	always_ff @(posedge clock) begin
		if (rst) begin
			alert_oe_q <= 1'b0;
			alert_out_q <= 1'b0;
		end else begin
			alert_oe_q <= |(status_q & ~mask_q);
			alert_out_q <= 1'b0;
		end
	end

	// checks
	logic [CODE_W-1:0] val_now;
	assign val_now = val_q[res_ch_q];

	a_alert_follows: assert property (@(posedge clock) disable iff (rst)
		##1 alert_oe_q == |($past(status_q) & ~$past(mask_q)))
		else $error("alert does not follow flags");
	a_ara_answer: assert property (@(posedge clock) disable iff (rst)
		req.ara && alert_oe_q |=> ara_ack_q &&
			reg_rdata_q == {DEV_ADDR, 1'b0})
		else $error("alert response missing");
	a_ara_quiet: assert property (@(posedge clock) disable iff (rst)
		req.ara && !alert_oe_q |=> !ara_ack_q)
		else $error("alert response while idle");
	a_status_high: assert property (@(posedge clock) disable iff (rst)
		store_q && result_q[CODE_W-1 -: 8] > high_q[res_ch_q]
			|=> status_q[$past(res_ch_q)])
		else $error("over limit not flagged");
	a_freeze_hold: assert property (@(posedge clock) disable iff (rst)
		store_q && lock_q[res_ch_q] |=> $stable(val_now))
		else $error("frozen reading changed");
	a_store_update: assert property (@(posedge clock) disable iff (rst)
		store_q && !lock_q[res_ch_q] |=> val_now == $past(result_q))
		else $error("reading not stored");
	a_avg_sixteen: assert property (@(posedge clock) disable iff (rst)
		single_channel_convert_end && !single && !avg_off && avg_n_q != 4'hF
			|=> !store_q)
		else $error("stored before sixteen samples");
	a_sample_time: assert property (@(posedge clock) disable iff (rst)
		adc_sample_q |-> $past(single_channel_convert_cnt_q) == 23'(SINGLE_CHANNEL_CONVERT_CYCLES - 1))
		else $error("conversion time wrong");
	a_bypass_all: assert property (@(posedge clock) disable iff (rst)
		cfg2_q[BYP_ALL_BIT] && adc_chan_q < 3'(ATT_CHANS) &&
			$stable(adc_chan_q) |=> adc_bypass_q)
		else $error("attenuator not bypassed");
	a_single_chan: assert property (@(posedge clock) disable iff (rst)
		single && store_q |-> res_ch_q == $past(adc_chan_q))
		else $error("single mode channel wrong");
	a_alert_release: assert property (@(posedge clock) disable iff (rst)
		req.rd && req.addr == STATUS_OFS && !store_q
			|=> status_q == ($past(status_q) & $past(oor_q)))
		else $error("status cleared wrongly");

	c_avg_store: cover property (@(posedge clock) disable iff (rst)
		store_q && !avg_off && !single);
	c_alert_ara: cover property (@(posedge clock) disable iff (rst)
		req.ara && alert_oe_q);
	c_freeze: cover property (@(posedge clock) disable iff (rst)
		store_q && lock_q[res_ch_q]);
	c_single: cover property (@(posedge clock) disable iff (rst)
		single && store_q);
endmodule
`default_nettype wire

// File: vmseq_adc_model.sv
`timescale 1ns/100ps
`default_nettype none
module vmseq_adc_model
	import vmseq_pkg::*;
(
	input wire logic [2:0] chan,
	output logic [CODE_W-1:0] code
);
	// one result per channel, set by the bench
	logic [CODE_W-1:0] codes [NCH];

	// every channel starts at nominal level
	initial begin
		foreach (codes[i]) codes[i] = NOMINAL_CODE;
	end

	// shared converter answers for the selected channel only
	assign code = (chan < 3'h7) ? codes[chan] : ~codes[0];
endmodule
`default_nettype wire

// File: voltage_monitor_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module voltage_monitor_sequencer_tb
	import vmseq_pkg::*;
;
	localparam int SINGLE_CHANNEL_CONVERT = 4;
	localparam logic [6:0] DEV = 7'h2C; // arbitrary value
	localparam int CYC = 1000;
	localparam int SLW = 1500;
	localparam logic [20:0] TBL [8] = '{
		{4'h0, 8'h40, 8'h10, 1'b1}, {4'h1, 8'h40, 8'h10, 1'b0},
		{4'h1, 8'h40, 8'h20, 1'b1}, {4'h2, 8'h60, 8'h00, 1'b1},
		{4'h8, 8'h60, 8'h00, 1'b0}, {4'h3, 8'h40, 8'h40, 1'b1},
		{4'h4, 8'h40, 8'h80, 1'b1}, {4'h9, 8'h40, 8'hF0, 1'b0}};
	logic clock;
	logic rst;
	vmseq_req_t req;
	logic [CODE_W-1:0] adc_code;
	logic [7:0] reg_rdata_q;
	logic ara_ack_q;
	logic [2:0] adc_chan_q;
	logic adc_bypass_q;
	logic adc_sample_q;
	logic alert_out_q;
	logic alert_oe_q;
	int n_mismatch;
	int n_tests;

	vmseq_top #(.SINGLE_CHANNEL_CONVERT_CYCLES(SINGLE_CHANNEL_CONVERT), .CYCLE_CYCLES(CYC), .SLOW_CYCLES(SLW),
		.DEV_ADDR(DEV)) i_vmseq_top (.clock(clock), .rst(rst), .req(req),
		.adc_code(adc_code), .reg_rdata_q(reg_rdata_q),
		.ara_ack_q(ara_ack_q), .adc_chan_q(adc_chan_q),
		.adc_bypass_q(adc_bypass_q), .adc_sample_q(adc_sample_q),
		.alert_out_q(alert_out_q), .alert_oe_q(alert_oe_q));
	vmseq_adc_model i_vmseq_adc_model (.chan(adc_chan_q), .code(adc_code));

	// clock generator
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e, g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task automatic step;
		@(posedge clock);
		#1;
	endtask

	// one request held for one edge, answer taken after it
	task automatic bus(input logic [2:0] k, input logic [7:0] a, d,
		output logic [7:0] q, output logic ack);
		@(posedge clock);
		req <= '{rd: k[0], wr: k[1], ara: k[2], addr: a, wdata: d};
		@(posedge clock);
		req <= '0;
		#1;
		q = reg_rdata_q;
		ack = ara_ack_q;
	endtask

	task automatic wr(input logic [7:0] a, d);
		logic [7:0] q;
		logic k;
		bus(3'b010, a, d, q, k);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		logic k;
		bus(3'b001, a, 8'h00, q, k);
	endtask

	// poll a register until it shows the expected value
	task automatic wait_read(input logic [7:0] a, e);
		logic [7:0] q;
		for (int i = 0; i < 300; i++) begin
			rd(a, q);
			if (q === e) break;
		end
		chk("polled reg", {8'h00, e}, {8'h00, q});
		if (q !== e) complete_run();
	endtask

	// count conversions taken on channel 0 during one stretch
	task automatic count_ch0(input logic skip, output int n);
		n = 0;
		for (int i = 0; i < 2000 && skip && adc_chan_q === 3'h0; i++) step();
		for (int i = 0; i < 2000 && adc_chan_q !== 3'h0; i++) step();
		for (int i = 0; i < 2000 && adc_chan_q === 3'h0; i++) begin
			step();
			n += int'(adc_sample_q);
		end
		repeat (2) begin
			step();
			n += int'(adc_sample_q);
		end
	endtask

	task automatic do_reset;
		@(posedge clock);
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
	endtask

	task automatic t_reset;
		logic [7:0] q;
		for (int i = 0; i < NCH; i++) begin
			rd(READ_OFS[i], q);
			chk("reading", {8'h00, READ_RST}, {8'h00, q});
			rd(LOW_OFS[i], q);
			chk("low limit", {8'h00, LOW_RST}, {8'h00, q});
			rd(HIGH_OFS[i], q);
			chk("high limit", {8'h00, HIGH_RST}, {8'h00, q});
		end
		rd(8'h00, q);
		chk("unmapped", 16'h0000, {8'h00, q});
	endtask

	task automatic t_avg;
		int n;
		do_reset();
		count_ch0(1'b0, n);
		chk("avg samples", 16'h0010, n[15:0]);
		wait_read(READ_OFS[0], 8'hC0);
		i_vmseq_adc_model.codes[0] = 10'h2C5;
		wr(CFG2_OFS, 8'h10);
		wait_read(READ_OFS[0], 8'hB1);
		count_ch0(1'b1, n);
		chk("single samples", 16'h0001, n[15:0]);
	endtask

	task automatic t_lock;
		logic [7:0] q;
		i_vmseq_adc_model.codes[0] = 10'h301;
		wait_read(READ_OFS[0], 8'hC0);
		rd(EXT_A_OFS, q);
		chk("ext low bits", 16'h0001, {14'h0000, q[1:0]});
		i_vmseq_adc_model.codes[0] = 10'h100;
		repeat (100) step();
		rd(READ_OFS[0], q);
		chk("locked reading", 16'h00C0, {8'h00, q});
		wait_read(READ_OFS[0], 8'h40);
	endtask

	task automatic t_alert;
		logic [7:0] q;
		logic k;
		i_vmseq_adc_model.codes[0] = NOMINAL_CODE;
		wr(HIGH_OFS[0], 8'h80);
		for (int i = 0; i < 300 && alert_oe_q !== 1'b1; i++) step();
		chk("alert on", 16'h0001, {15'h0000, alert_oe_q});
		chk("alert level", 16'h0000, {15'h0000, alert_out_q});
		rd(STATUS_OFS, q);
		chk("status", 16'h0001, {15'h0000, q[0]});
		bus(3'b100, 8'h00, 8'h00, q, k);
		chk("ara ack", 16'h0001, {15'h0000, k});
		chk("ara data", {8'h00, DEV, 1'b0}, {8'h00, q});
		wr(HIGH_OFS[0], 8'hFF);
		repeat (100) step();
		rd(STATUS_OFS, q);
		repeat (4) step();
		chk("alert off", 16'h0000, {15'h0000, alert_oe_q});
		bus(3'b100, 8'h00, 8'h00, q, k);
		chk("idle ara ack", 16'h0000, {15'h0000, k});
		chk("idle ara data", 16'h0000, {8'h00, q});
	endtask

	task automatic t_single;
		logic [3:0] s;
		for (int i = 0; i < 8; i++) begin
			s = TBL[i][20:17];
			wr(CHSEL_OFS, {s, 4'h0});
			wr(CFG4_OFS, TBL[i][8:1]);
			wr(CFG2_OFS, TBL[i][16:9]);
			repeat (3 * SINGLE_CHANNEL_CONVERT + 6) step();
			chk("chan", {13'h0000, (s < 4'h5) ? s[2:0] : 3'(s - 4'h3)},
				{13'h0000, adc_chan_q});
			chk("bypass", {15'h0000, TBL[i][0]},
				{15'h0000, adc_bypass_q});
		end
	endtask

	// measures one round-robin pass, idle start to idle start
	task automatic pass_time(input logic [7:0] c6, output int n);
		wr(CFG2_OFS, 8'h00);
		wr(CFG6_OFS, c6);
		n = 0;
		for (int k = 0; k < 3; k++) begin
			n = 0;
			for (int i = 0; i < 3000 && adc_chan_q !== 3'h6; i++) begin
				step();
				n++;
			end
			for (int i = 0; i < 3000 && adc_chan_q !== 3'h0; i++) begin
				step();
				n++;
			end
		end
	endtask

	task automatic t_pass;
		int n;
		pass_time(8'h80, n);
		chk("slow pass", 16'(SLW), n[15:0]);
		pass_time(8'h00, n);
		chk("default pass", 16'(CYC), n[15:0]);
	endtask

	// main sequence
	initial begin
		rst = 1'b1;
		req = '0;
		n_mismatch = 0;
		n_tests = 0;
		do_reset();
		t_reset();
		t_avg();
		t_lock();
		t_alert();
		t_single();
		t_pass();
		complete_run();
	end

	// cuts a hang short
	initial begin
		repeat (60000) @(posedge clock);
		n_mismatch++;
		complete_run();
	end
endmodule
`default_nettype wire
